// file: inc/fwa_pkg.sv
// Purpose: shared constants and carriers for the fronthaul window alignment block
// Assumes: all delays are signed counts of one common time unit, referenced to Ra
// Notes:   the time unit is set by the integrator; 1 ns is the natural choice
package fwa_pkg;
   localparam int DW       = 24;          // Signed delay width
   localparam int NSET     = 4;           // Selectable window sets
   localparam int SW       = 2;           // Set index width
   localparam int PRACH_SW = 4;           // PRACH symbol index width
   localparam logic [PRACH_SW-1:0] PRACH_SYM_MAX = 4'hD; // Last symbol index served

   // Reporting tolerance of the radio delays, ns
   localparam int RU_TOL_NS     = 200;
   localparam int CLK_PERIOD_NS = 50;
   // Evaluation pipeline latency in cycles, start to done
   localparam int EVAL_CYCLES   = 3;

   // Radio unit delay profile, domain worst case
   typedef struct packed {
      logic signed [DW-1:0] t2a_min_up;
      logic signed [DW-1:0] t2a_max_up;
      logic signed [DW-1:0] t2a_min_cp_dl;
      logic signed [DW-1:0] t2a_max_cp_dl;
      logic signed [DW-1:0] t2a_min_cp_ul;
      logic signed [DW-1:0] t2a_max_cp_ul;
      logic signed [DW-1:0] ta3_min;
      logic signed [DW-1:0] ta3_max;
      logic signed [DW-1:0] tcp_adv_dl;
   } fwa_ru_prof_t;

   // Transport characteristics
   typedef struct packed {
      logic                 measured;     // 1: measured method, 0: defined method
      logic signed [DW-1:0] t12_min;
      logic signed [DW-1:0] t12_max;      // Defined method only
      logic signed [DW-1:0] t34_min;
      logic signed [DW-1:0] t34_max;      // Defined method only
      logic signed [DW-1:0] pdv_max;      // Contracted variation, measured method
   } fwa_tn_prof_t;

   // One candidate set of distributed unit windows
   typedef struct packed {
      logic signed [DW-1:0] t1a_max_up;
      logic signed [DW-1:0] t1a_min_up;
      logic signed [DW-1:0] t1a_max_cp_dl;
      logic signed [DW-1:0] t1a_min_cp_dl;
      logic signed [DW-1:0] t1a_max_cp_ul;
      logic signed [DW-1:0] t1a_min_cp_ul;
      logic signed [DW-1:0] ta4_min;
      logic signed [DW-1:0] ta4_max;
   } fwa_win_t;

   // Design capability limits of the distributed unit
   typedef struct packed {
      logic signed [DW-1:0] txmax_up;
      logic signed [DW-1:0] txmax_cp;
      logic signed [DW-1:0] t1a_max_up_cap;
      logic signed [DW-1:0] rxmax;
      logic signed [DW-1:0] ta4_max_cap;
   } fwa_cap_t;

   // PRACH reference point request
   typedef struct packed {
      logic signed [DW-1:0] time_offset;
      logic signed [DW-1:0] cp_length;
      logic signed [DW-1:0] fft_offset;
      logic signed [DW-1:0] sym_dur;
      logic [PRACH_SW-1:0]  sym_idx;
   } fwa_prach_req_t;
endpackage

// file: src/fwa_align.sv
// Purpose: window alignment check and PRACH reference point for the distributed unit
// Assumes: inputs synchronous to core_clk_i; profiles stable while evaluating
// Notes:   walks the window sets in order, keeps the first that fits, flags when none fits
module fwa_align #(
   parameter int N = fwa_pkg::NSET
) (
   input  wire logic                        core_clk_i,
   input  wire logic                        reset_i,
   input  wire fwa_pkg::fwa_ru_prof_t       ru_i,
   input  wire fwa_pkg::fwa_tn_prof_t       tn_i,
   input  wire fwa_pkg::fwa_cap_t           cap_i,
   input  wire logic                        set_wr_i,
   input  wire logic [fwa_pkg::SW-1:0]      set_idx_i,
   input  wire fwa_pkg::fwa_win_t           set_data_i,
   input  wire logic                        eval_start_i,
   input  wire logic signed [fwa_pkg::DW-1:0] now_adv_i,
   input  wire logic                        prach_req_i,
   input  wire fwa_pkg::fwa_prach_req_t     prach_i,
   output logic                             busy_o,
   output logic                             done_o,
   output logic                             fit_o,
   output logic                             notify_o,
   output logic [fwa_pkg::SW-1:0]           sel_o,
   output fwa_pkg::fwa_win_t                win_o,
   output logic                             tx_up_ok_o,
   output logic                             tx_cp_dl_ok_o,
   output logic                             tx_cp_ul_ok_o,
   output logic                             rx_up_ok_o,
   output logic                             cp_lead_ok_o,
   output logic                             prach_vld_o,
   output logic signed [fwa_pkg::DW-1:0]    prach_ref_o
);
   localparam int DW = fwa_pkg::DW;

   // Search index is SW bits wide, so more sets could never be walked
   if (N < 1 || N > (1 << fwa_pkg::SW)) begin
      $error("fwa_align: bad N");
   end

   typedef enum {ST_IDLE, ST_READ, ST_CHECK, ST_DONE} fwa_st_t;

   typedef struct packed {
      fwa_st_t                 st;
      logic [fwa_pkg::SW-1:0]  idx;
      logic                    busy;
      logic                    done;
      logic                    fit;
      logic                    notify;
      logic [fwa_pkg::SW-1:0]  sel;
      fwa_pkg::fwa_win_t       win;
      logic                    tx_up_ok;
      logic                    tx_cp_dl_ok;
      logic                    tx_cp_ul_ok;
      logic                    rx_up_ok;
      logic                    cp_lead_ok;
      logic                    prach_vld;
      logic signed [DW-1:0]    prach_ref;
   } fwa_state_t;

   fwa_state_t        s;
   fwa_state_t        next_s;
   fwa_pkg::fwa_win_t cand;

   fwa_set_rom #(.N(N)) u_rom (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .wr_en_i    (set_wr_i),
      .wr_idx_i   (set_idx_i),
      .wr_data_i  (set_data_i),
      .rd_idx_i   (next_s.idx),
      .rd_data_o  (cand)
   );

   // Inclusive range test, shared by all window gates
   function automatic logic in_win(input logic signed [DW-1:0] v,
                                   input logic signed [DW-1:0] lo,
                                   input logic signed [DW-1:0] hi);
      in_win = (v >= lo) && (v <= hi);
   endfunction

   // Transport bounds per method; widened sums avoid wrap
   logic signed [DW:0] t12_max;
   logic signed [DW:0] t34_max;
   always_comb begin
      if (tn_i.measured) begin
         t12_max = (DW+1)'(tn_i.t12_min) + (DW+1)'(tn_i.pdv_max);
         t34_max = (DW+1)'(tn_i.t34_min) + (DW+1)'(tn_i.pdv_max);
      end else begin
         t12_max = (DW+1)'(tn_i.t12_max);
         t34_max = (DW+1)'(tn_i.t34_max);
      end
   end

   // Every inequality on one candidate set, one comparator each
   logic signed [DW+1:0] w;
   logic [13:0] ok;
   always_comb begin
      w     = '0;
      ok[0] = (DW+2)'(cand.t1a_max_up) <= (DW+2)'(ru_i.t2a_max_up) + (DW+2)'(tn_i.t12_min);
      ok[1] = (DW+2)'(cand.t1a_min_up) >= (DW+2)'(ru_i.t2a_min_up) + (DW+2)'(t12_max);
      ok[2] = (DW+2)'(cand.t1a_max_cp_dl)
              <= (DW+2)'(ru_i.t2a_max_cp_dl) + (DW+2)'(tn_i.t12_min);
      ok[3] = (DW+2)'(cand.t1a_min_cp_dl)
              >= (DW+2)'(ru_i.t2a_min_cp_dl) + (DW+2)'(t12_max);
      ok[4] = (DW+2)'(cand.ta4_min) <= (DW+2)'(ru_i.ta3_min) + (DW+2)'(tn_i.t34_min);
      ok[5] = (DW+2)'(cand.ta4_max) >= (DW+2)'(ru_i.ta3_max) + (DW+2)'(t34_max);
      ok[6] = (DW+2)'(cand.t1a_min_cp_ul)
              >= (DW+2)'(ru_i.t2a_min_cp_ul) + (DW+2)'(t12_max);
      ok[7] = (DW+2)'(cand.t1a_max_cp_ul)
              <= (DW+2)'(ru_i.t2a_max_cp_ul) + (DW+2)'(tn_i.t12_min);
      w     = (DW+2)'(cand.t1a_max_up) - (DW+2)'(cand.t1a_min_up);
      ok[8] = w >= (DW+2)'(cap_i.txmax_up);
      ok[9] = cand.t1a_max_up <= cap_i.t1a_max_up_cap;
      ok[10] = (DW+2)'(cand.ta4_max) - (DW+2)'(cand.ta4_min) <= (DW+2)'(cap_i.rxmax);
      ok[11] = cand.ta4_max <= cap_i.ta4_max_cap;
      ok[12] = (DW+2)'(cand.t1a_max_cp_dl) - (DW+2)'(cand.t1a_min_cp_dl)
               >= (DW+2)'(cap_i.txmax_cp);
      ok[13] = cand.ta4_min <= cand.ta4_max;
   end

   // Search, gate and PRACH next-state logic in one place
   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      case (s.st)
         ST_IDLE: begin
            if (eval_start_i) begin
               next_s.st     = ST_READ;
               next_s.idx    = '0;
               next_s.busy   = 1'b1;
            end
         end
         ST_READ: next_s.st = ST_CHECK;
         ST_CHECK: begin
            if (&ok) begin
               next_s.st     = ST_DONE;
               next_s.fit    = 1'b1;
               next_s.notify = 1'b0;
               next_s.sel    = s.idx;
               next_s.win    = cand;
            end else if (32'(s.idx) == N - 1) begin
               next_s.st     = ST_DONE;
               next_s.fit    = 1'b0;
               next_s.notify = 1'b1;
            end else begin
               next_s.st  = ST_READ;
               next_s.idx = s.idx + 1'b1;
            end
         end
         ST_DONE: begin
            next_s.st   = ST_IDLE;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end
         default: next_s.st = ST_IDLE;
      endcase
      // Gates stay closed until a set is held; old set kept while re-searching
      next_s.tx_up_ok    = s.fit && in_win(now_adv_i, s.win.t1a_min_up, s.win.t1a_max_up);
      next_s.tx_cp_dl_ok = s.fit
                           && in_win(now_adv_i, s.win.t1a_min_cp_dl, s.win.t1a_max_cp_dl);
      next_s.tx_cp_ul_ok = s.fit
                           && in_win(now_adv_i, s.win.t1a_min_cp_ul, s.win.t1a_max_cp_ul);
      // Uplink latency measured as a delay after Ra, same signed axis
      next_s.rx_up_ok    = s.fit && in_win(now_adv_i, s.win.ta4_min, s.win.ta4_max);
      // C-Plane advance must beat latest U-Plane arrival by Tcp_adv_dl
      next_s.cp_lead_ok  = s.fit && ((DW+2)'(s.win.t1a_min_cp_dl)
                           >= (DW+2)'(s.win.t1a_min_up) + (DW+2)'(ru_i.tcp_adv_dl));
      // PRACH reference, one cycle after the request
      next_s.prach_vld = prach_req_i && (prach_i.sym_idx <= fwa_pkg::PRACH_SYM_MAX);
      if (prach_req_i) begin
         next_s.prach_ref = prach_i.time_offset + prach_i.cp_length - prach_i.fft_offset
                            + prach_i.sym_dur * $signed(DW'(prach_i.sym_idx));
      end
   end

   // Single state register
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s    <= '0;
         s.st <= ST_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign busy_o        = s.busy;
   assign done_o        = s.done;
   assign fit_o         = s.fit;
   assign notify_o      = s.notify;
   assign sel_o         = s.sel;
   assign win_o         = s.win;
   assign tx_up_ok_o    = s.tx_up_ok;
   assign tx_cp_dl_ok_o = s.tx_cp_dl_ok;
   assign tx_cp_ul_ok_o = s.tx_cp_ul_ok;
   assign rx_up_ok_o    = s.rx_up_ok;
   assign cp_lead_ok_o  = s.cp_lead_ok;
   assign prach_vld_o   = s.prach_vld;
   assign prach_ref_o   = s.prach_ref;

   // Set taken as fit_o rises honours the downlink U bounds
   dl_up_fit_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      $rose(fit_o) |-> $past(ok[0]) && $past(ok[1]) && $past(ok[8]))
      else $error("DL U window accepted while violating bounds");
   ul_rx_fit_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (s.st == ST_CHECK && &ok) |=> (fit_o && win_o.ta4_max == $past(cand.ta4_max)))
      else $error("UL receive window not taken from fitting set");
   no_fit_note_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (s.st == ST_CHECK && !(&ok) && 32'(s.idx) == N - 1) |=> notify_o ##1 done_o)
      else $error("No notification after last set failed");
   notify_excl_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !(notify_o && fit_o))
      else $error("Fit and notify both set");
   tx_gate_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      tx_up_ok_o |-> $past(now_adv_i) <= win_o.t1a_max_up || $past(s.win) != win_o)
      else $error("DL U send allowed above window");
   cp_gate_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !$past(fit_o) |-> !tx_cp_dl_ok_o && !tx_cp_ul_ok_o)
      else $error("C-Plane send allowed without a window");
   prach_step_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (prach_req_i && prach_i.sym_idx == '0) |=> prach_ref_o
      == $past(prach_i.time_offset) + $past(prach_i.cp_length) - $past(prach_i.fft_offset))
      else $error("PRACH reference for first symbol wrong");
   eval_time_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (s.st == ST_IDLE && eval_start_i) |-> ##[3:12] done_o)
      else $error("Evaluation did not finish in time");
endmodule

// file: src/fwa_set_rom.sv
// Purpose: small table of selectable distributed unit window sets
// Assumes: sets are loaded by the wr port between evaluations, never during one
// Notes:   read data come out of a register, one cycle after the address
module fwa_set_rom #(
   parameter int N = fwa_pkg::NSET
) (
   input  wire logic                    core_clk_i,
   input  wire logic                    reset_i,
   input  wire logic                    wr_en_i,
   input  wire logic [fwa_pkg::SW-1:0]  wr_idx_i,
   input  wire fwa_pkg::fwa_win_t       wr_data_i,
   input  wire logic [fwa_pkg::SW-1:0]  rd_idx_i,
   output fwa_pkg::fwa_win_t            rd_data_o
);
   fwa_pkg::fwa_win_t mem [N];

   // Index is SW bits wide, so more sets could never be addressed
   if (N < 1 || N > (1 << fwa_pkg::SW)) begin
      $error("fwa_set_rom: bad N");
   end

   // Storage and registered read
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rd_data_o <= '0;
      end else begin
         if (wr_en_i) mem[wr_idx_i] <= wr_data_i;
         rd_data_o <= mem[rd_idx_i];
      end
   end
endmodule

// file: tb/fwa_ru_model.sv
// Purpose: radio unit and transport profile facing the alignment block
// Assumes: profile stays fixed while a search runs
// Notes:   all values in ns relative to Ra; mode_i picks one of four profiles
module fwa_ru_model (
   input  wire logic [1:0]            mode_i,
   output fwa_pkg::fwa_ru_prof_t      ru_o,
   output fwa_pkg::fwa_tn_prof_t      tn_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Windows anchored to the fixed Ra point, in whole ns, not on a 200 ns grid
   // Mode 3 widens the C-Plane lead beyond the DL C margin of the sets, clearing cp_lead_ok
   always_comb begin
      ru_o = '{100, 150, 120, 200, 120, 200, 10, 40, (mode_i == 2'h3) ? 21 : 10};
   end

   // Mode 1 is measured: its max fields are junk, only min plus variation counts
   always_comb begin
      case (mode_i)
         2'h1:    tn_o = '{1'b1, 50, 999, 50, 999, 15};
         2'h2:    tn_o = '{1'b0, 50, 66, 50, 65, 15};
         default: tn_o = '{1'b0, 50, 65, 50, 65, 15};
      endcase
   end
endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench for the window alignment block
// Assumes: window sets sit exactly on the inequality bounds of the radio profile
// Notes:   every reject case moves one bound by 1 ns, so off-by-one slips show up
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int N = fwa_pkg::NSET;
   localparam fwa_pkg::fwa_win_t BASE = '{200, 165, 250, 185, 250, 185, 60, 105};
   localparam fwa_pkg::fwa_cap_t CAP0 = '{35, 65, 200, 45, 105};
   logic                          core_clk_i, reset_i, set_wr_i, eval_start_i, prach_req_i;
   logic [1:0]                    mode;
   logic [fwa_pkg::SW-1:0]        set_idx_i, sel;
   logic signed [fwa_pkg::DW-1:0] now_adv_i, pref;
   fwa_pkg::fwa_ru_prof_t         ru;
   fwa_pkg::fwa_tn_prof_t         tn;
   fwa_pkg::fwa_cap_t             cap;
   fwa_pkg::fwa_win_t             set_data_i, win;
   fwa_pkg::fwa_prach_req_t       prach_i;
   logic                          busy, done, fit, notify, txu, txd, txc, rxu, lead, pvld;
   int                            fails, samples_checked;

   fwa_ru_model ru_model (.mode_i(mode), .ru_o(ru), .tn_o(tn));
   fwa_align #(.N(N)) dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .ru_i(ru), .tn_i(tn),
      .cap_i(cap), .set_wr_i(set_wr_i), .set_idx_i(set_idx_i), .set_data_i(set_data_i),
      .eval_start_i(eval_start_i), .now_adv_i(now_adv_i), .prach_req_i(prach_req_i),
      .prach_i(prach_i), .busy_o(busy), .done_o(done), .fit_o(fit), .notify_o(notify),
      .sel_o(sel), .win_o(win), .tx_up_ok_o(txu), .tx_cp_dl_ok_o(txd), .tx_cp_ul_ok_o(txc),
      .rx_up_ok_o(rxu), .cp_lead_ok_o(lead), .prach_vld_o(pvld), .prach_ref_o(pref));

   // 20 MHz core clock
   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end

   // Inputs always move 5 ns after the rising edge
   task automatic tick();
      @(posedge core_clk_i);
      #5;
   endtask

   task automatic chk(input string what, input logic signed [31:0] exp, got);
      samples_checked++;
      if (exp !== got) begin
         fails++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // Strobe stays high across the four writes, so it is never set twice in one step
   task automatic load(input fwa_pkg::fwa_win_t w [4]);
      set_wr_i = 1'b1;
      for (int i = 0; i < 4; i++) begin
         set_idx_i = i[1:0];
         set_data_i = w[i];
         tick();
      end
      set_wr_i = 1'b0;
   endtask

   // Bounded wait: a full walk takes 2N+1 edges
   task automatic search(input logic f, input int s);
      int k;
      eval_start_i = 1'b1;
      tick();
      eval_start_i = 1'b0;
      chk("busy", 1, busy);
      for (k = 0; k < 2 * N + 4 && done !== 1'b1; k++) tick();
      chk("done", 1, done);
      chk("busy end", 0, busy);
      chk("fit", f, fit);
      chk("notify", !f, notify);
      if (f) chk("sel", s, sel);
   endtask

   // First fitting set wins; set 0 ahead of it breaks two bounds, set 1 one bound
   task automatic sc_select();
      fwa_pkg::fwa_win_t w [4];
      w = '{BASE, BASE, BASE, BASE};
      w[0].t1a_max_up = 201;
      w[1].t1a_min_up = 164;
      load(w);
      search(1'b1, 2);
      chk("win", 1, win === BASE);
   endtask

   // Each case breaks exactly one inequality or capability by 1 ns, except case 0, which also breaks t1a_max_up_cap
   task automatic sc_reject();
      fwa_pkg::fwa_win_t w;
      for (int k = 0; k < 13; k++) begin
         w = BASE;
         cap = CAP0;
         case (k)
            0: w.t1a_max_up = 201;
            1: w.t1a_min_up = 164;
            2: w.t1a_max_cp_dl = 251;
            3: w.t1a_min_cp_dl = 184;
            4: w.ta4_min = 61;
            5: w.ta4_max = 104;
            6: w.t1a_min_cp_ul = 184;
            7: w.t1a_max_cp_ul = 251;
            8: cap.txmax_up = 36;
            9: cap.t1a_max_up_cap = 199;
            10: cap.rxmax = 44;
            11: cap.ta4_max_cap = 104;
            default: cap.txmax_cp = 66;
         endcase
         load('{w, w, w, w});
         search(1'b0, 0);
      end
      cap = CAP0;
      load('{BASE, BASE, BASE, BASE});
      search(1'b1, 0);
   endtask

   // Transport method and C-Plane lead, tx_up gate drops to 0 without a fit
   task automatic sc_transport();
      mode = 2'h1;
      search(1'b1, 0);
      mode = 2'h3;
      search(1'b1, 0);
      chk("lead", 0, lead);
      mode = 2'h2;
      now_adv_i = 185;
      search(1'b0, 0);
      chk("tx_up gated", 0, txu);
      mode = 2'h0;
      search(1'b1, 0);
      chk("lead", 1, lead);
   endtask

   // Gates probed just inside and outside every inclusive bound
   task automatic sc_gates();
      int v [12] = '{164, 165, 200, 201, 184, 185, 250, 251, 59, 60, 105, 106};
      foreach (v[i]) begin
         now_adv_i = v[i];
         tick();
         chk("tx_up", v[i] >= 165 && v[i] <= 200, txu);
         chk("tx_cp_dl", v[i] >= 185 && v[i] <= 250, txd);
         chk("tx_cp_ul", v[i] >= 185 && v[i] <= 250, txc);
         chk("rx_up", v[i] >= 60 && v[i] <= 105, rxu);
      end
   endtask

   // PRACH reference with fft offset 7 and symbol duration 800
   // Strobe stays high across back-to-back requests; the caller drops it
   task automatic prach(input int cp, input int idx, input logic v, input int exp);
      prach_i = '{1000, cp, 7, 800, idx[3:0]};
      prach_req_i = 1'b1;
      tick();
      chk("prach_vld", v, pvld);
      if (v) chk("prach_ref", exp, pref);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Main sequence after a 12 cycle reset
   initial begin
      fails = 0;
      samples_checked = 0;
      {reset_i, set_wr_i, eval_start_i, prach_req_i} = 4'h8;
      mode = 2'h0;
      set_idx_i = '0;
      set_data_i = BASE;
      cap = CAP0;
      now_adv_i = 0;
      prach_i = '0;
      repeat (12) @(posedge core_clk_i);
      #5;
      reset_i = 1'b0;
      chk("idle done", 0, done);
      sc_select();
      sc_reject();
      sc_transport();
      sc_gates();
      prach(300, 0, 1'b1, 1293);
      prach(0, 0, 1'b1, 993);
      prach(300, 3, 1'b1, 3693);
      prach(0, 13, 1'b1, 11393);
      prach(0, 14, 1'b0, 0);
      prach_req_i = 1'b0;
      complete_run();
   end

   // Whole run needs well under 2000 cycles
   initial begin
      #(50 * 20000);
      fails++;
      complete_run();
   end
endmodule
